// [rtl/sat_params.sv]
/*
  sat_params: parameter registers, auto-tuning sequencer and fault
  supervision of a servo drive, reached over APB.
  assumes drive inputs synchronous to pclk; fault inputs are magnitudes.
*/
// Added by the designer: the APB register port.
`timescale 1ns/10ps

// What this block does
// [R1] selector 0: inputs pass through normally
// [R2] selector 1: force servo on, ignore inhibits
// [R3] selector 2: ignore clockwise inhibit only
// [R4] selector 3: ignore counterclockwise inhibit; 4 reserved
// [R5] selector 5: no nonvolatile parameter writes
// [R6] selector returns to 0 at power-up
// [R7] stiffness level maps to bandwidth table
// [R8] bandwidth rises with stiffness level
// [R9] stiffness applies only in auto modes
// [R10] mode 2: fixed inertia, gains from stiffness
// [R11] loop field 0 feedforward, 1 PI
// [R12] leaving mode 1 for mode 0 or 2 stores measured inertia, gains
// [R13] mode 1 stores inertia every 30 minutes
// [R14] mode 2 stiffness change updates gains only
// [R15] mode 2 to 0 restores manual values
// [R16] speed mode overspeed raises fault 07
// [R17] position mode excess error raises 09
// [R18] faults latch until cleared, code reported
module sat_params
  import sat_pkg::*;
#(
  parameter logic [39:0] SAVE_CYCLES = 40'(sat_pkg::SAVE_CYC)  // periodic save interval
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire sat_pkg::sat_in_t  drv_in,
  output sat_pkg::sat_out_t      drv_out,
  output logic                   irq
);
  import sat_pkg::*;

  // whole block state in one record
  typedef struct packed {
    logic [2:0]  aux;      // auxiliary function selector
    logic [3:0]  stiff;    // stiffness level
    logic [15:0] os_thr;   // overspeed threshold, rpm
    logic [15:0] pe_thr;   // position error threshold, 10 pulses
    logic [1:0]  mode;     // tuning mode
    logic [1:0]  prev;     // tuning mode one cycle ago
    logic        loop_pi;  // loop structure field
    logic [15:0] inertia;  // inertia ratio setting
    logic [7:0]  bw;       // speed-loop gain as bandwidth
    logic [15:0] snap_in;  // manual inertia kept while auto
    logic [7:0]  snap_bw;  // manual gain kept while auto
    logic [2:0]  sts;      // sticky event status
    logic [2:0]  en;       // interrupt enables
    logic [39:0] tmr;      // periodic save timer
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        irq;
    sat_out_t    o;
  } sat_state_t;

  localparam sat_state_t ST_RST = '{
    aux: AUX_NORMAL, stiff: STIFF_RST, os_thr: OS_RST, pe_thr: PE_RST,
    inertia: INERTIA_RST, bw: GAIN_RST, snap_in: INERTIA_RST, snap_bw: GAIN_RST,
    default: '0};

  sat_state_t s_q;     // registered state
  sat_state_t s_d;     // next state
  logic [9:0] a;       // word index of the access
  logic       wr;      // write taken this edge
  logic       os_hit;  // overspeed seen now
  logic       pe_hit;  // excess error seen now
  logic       save_ev; // inertia stored by hardware
  logic [2:0] clr;     // status bits cleared by software

  // table lookup shared by sequencer and checks
  function automatic logic [7:0] bw_of(input logic [3:0] lvl);
    return BW_HZ[lvl];  // [R7] [R8]
  endfunction

  // keep a threshold inside its legal range
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    if (v < lo) begin
      return lo;
    end
    return (v > hi) ? hi : v;
  endfunction

  // next-state logic
  always_comb begin
    s_d     = s_q;
    a       = paddr[11:2];
    wr      = psel & penable & pwrite & s_q.ready;
    clr     = 3'h0;
    save_ev = 1'b0;

    // apb: data and answer prepared in setup, one access cycle
    s_d.ready = psel & ~penable;
    s_d.rdata = 32'h0;
    s_d.err   = 1'b0;
    if (psel & ~penable) begin
      case (a)
        IDX_AUX:     s_d.rdata = {29'h0, s_q.aux};
        IDX_STIFF:   s_d.rdata = {28'h0, s_q.stiff};
        IDX_RSVD_A:  s_d.rdata = 32'h0;  // reserved slot reads zero
        IDX_OS_THR:  s_d.rdata = {16'h0, s_q.os_thr};
        IDX_PE_THR:  s_d.rdata = {16'h0, s_q.pe_thr};
        IDX_TUNE:    s_d.rdata = {27'h0, s_q.loop_pi, 2'h0, s_q.mode};
        IDX_INERTIA: s_d.rdata = {16'h0, s_q.inertia};
        IDX_GAIN:    s_d.rdata = {24'h0, s_q.bw};
        IDX_FAULT:   s_d.rdata = {24'h0, s_q.o.fault_code};  // [R18]
        IDX_IRQ_STS: s_d.rdata = {29'h0, s_q.sts};
        IDX_IRQ_CLR: s_d.rdata = 32'h0;  // write-only
        IDX_IRQ_EN:  s_d.rdata = {29'h0, s_q.en};
        default:     s_d.err   = 1'b1;   // unmapped: slave error
      endcase
    end

    // software writes; hardware updates below take priority
    if (wr) begin
      case (a)
        IDX_AUX: begin
          // codes above 5 are dropped; reserved code 4 is still stored
          if (pwdata[15:0] <= 16'(AUX_VOLAT)) begin
            s_d.aux = pwdata[2:0];
          end
        end
        IDX_STIFF:   s_d.stiff  = pwdata[3:0];
        IDX_OS_THR:  s_d.os_thr = clamp(pwdata[15:0], OS_MIN, OS_MAX);
        IDX_PE_THR:  s_d.pe_thr = clamp(pwdata[15:0], PE_MIN, PE_MAX);
        IDX_TUNE: begin
          s_d.mode    = pwdata[TUNE_MODE_LSB +: 2];
          s_d.loop_pi = pwdata[TUNE_LOOP_BIT];
        end
        IDX_INERTIA: s_d.inertia = pwdata[15:0];
        IDX_GAIN:    s_d.bw      = pwdata[7:0];
        IDX_IRQ_CLR: clr         = pwdata[2:0];
        IDX_IRQ_EN:  s_d.en      = pwdata[2:0];
        default: ;
      endcase
    end

    // tuning sequencer, driven by mode transitions
    s_d.prev = s_q.mode;
    if (s_q.mode == M_AUTO1 && s_q.prev == M_AUTO1) begin
      s_d.tmr = (s_q.tmr == SAVE_CYCLES - 40'h1) ? 40'h0 : s_q.tmr + 40'h1;
    end else begin
      s_d.tmr = 40'h0;
    end
    if (s_q.prev != s_q.mode) begin
      // leaving manual: remember its values for a later restore
      if (s_q.prev == M_MAN) begin
        s_d.snap_in = s_q.inertia;
        s_d.snap_bw = s_q.bw;
      end
      // leaving auto 1 for manual or auto 2 keeps what was measured
      if (s_q.prev == M_AUTO1 && (s_q.mode == M_AUTO2 || s_q.mode == M_MAN)) begin
        s_d.inertia = drv_in.meas_inertia;  // [R12]
        s_d.bw      = bw_of(s_q.stiff);     // [R12]
        save_ev     = 1'b1;
      end
      // auto 2 back to manual puts the manual values back
      if (s_q.prev == M_AUTO2 && s_q.mode == M_MAN) begin
        s_d.inertia = s_q.snap_in;  // [R15]
        s_d.bw      = s_q.snap_bw;  // [R15]
      end
    end else if (s_q.mode == M_AUTO1) begin
      // auto 1 tracks the gain and saves inertia on the long timer
      s_d.bw = bw_of(s_q.stiff);  // [R9]
      if (s_q.tmr == SAVE_CYCLES - 40'h1) begin
        s_d.inertia = drv_in.meas_inertia;  // [R13]
        save_ev     = 1'b1;
      end
    end else if (s_q.mode == M_AUTO2) begin
      // fixed inertia: only the gain follows the stiffness level
      s_d.bw = bw_of(s_q.stiff);  // [R10] [R14]
    end
    // manual and reserved mode 3 leave the gain to software [R9]

    // fault detection against the programmed thresholds
    os_hit = (drv_in.ctrl_mode == CM_SPEED) && (drv_in.speed_rpm > s_q.os_thr);  // [R16]
    pe_hit = (drv_in.ctrl_mode == CM_POS)
             && (drv_in.pos_err > 32'({16'h0, s_q.pe_thr} * PE_UNIT));          // [R17]

    // sticky status: a new event beats a clear in the same cycle
    s_d.sts = s_q.sts & ~clr;
    s_d.sts[ST_OVSPD] = s_d.sts[ST_OVSPD] | os_hit;  // [R18]
    s_d.sts[ST_PERR]  = s_d.sts[ST_PERR] | pe_hit;   // [R18]
    s_d.sts[ST_SAVE]  = s_d.sts[ST_SAVE] | save_ev;
    s_d.irq = |(s_d.sts & s_d.en);

    // drive outputs, all taken from flops
    s_d.o.servo_on = (s_q.aux == AUX_FORCE) ? 1'b1 : drv_in.servo_on;  // [R1] [R2]
    s_d.o.cw_inh   = (s_q.aux == AUX_FORCE || s_q.aux == AUX_NO_CW)
                     ? 1'b0 : drv_in.cw_inh;                            // [R2] [R3]
    s_d.o.ccw_inh  = (s_q.aux == AUX_FORCE || s_q.aux == AUX_NO_CCW)
                     ? 1'b0 : drv_in.ccw_inh;                           // [R2] [R4]
    // volatile mode spares the parameter store from wear
    s_d.o.nv_write_en = (s_q.aux != AUX_VOLAT);  // [R5]
    s_d.o.loop_pi     = s_q.loop_pi;             // [R11]
    s_d.o.bw_hz       = s_q.bw;
    s_d.o.inertia     = s_q.inertia;
    // overspeed is shown first when both are pending
    if (s_d.sts[ST_OVSPD]) begin
      s_d.o.fault_code = FC_OVSPD;  // [R16] [R18]
    end else if (s_d.sts[ST_PERR]) begin
      s_d.o.fault_code = FC_PERR;   // [R17] [R18]
    end else begin
      s_d.o.fault_code = FC_NONE;
    end
  end

  // state register; power-up clears the selector to normal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= ST_RST;  // [R6]
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata  = s_q.rdata;
  assign pready  = s_q.ready;
  assign pslverr = s_q.err;
  assign drv_out = s_q.o;
  assign irq     = s_q.irq;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_aux_normal: assert property (s_q.aux == AUX_NORMAL |=> drv_out.servo_on == $past(drv_in.servo_on)
                                 && drv_out.cw_inh == $past(drv_in.cw_inh)
                                 && drv_out.ccw_inh == $past(drv_in.ccw_inh)) // [R1]
    else $error("normal selector altered inputs");
  a_aux_force: assert property (s_q.aux == AUX_FORCE |=> drv_out.servo_on
                                && !drv_out.cw_inh && !drv_out.ccw_inh) // [R2]
    else $error("force servo on not applied");
  a_aux_cw_ign: assert property (s_q.aux == AUX_NO_CW |=> !drv_out.cw_inh
                                 && drv_out.ccw_inh == $past(drv_in.ccw_inh)) // [R3]
    else $error("clockwise ignore wrong");
  a_aux_ccw_ign: assert property (s_q.aux == AUX_NO_CCW |=> !drv_out.ccw_inh
                                  && drv_out.cw_inh == $past(drv_in.cw_inh)) // [R4]
    else $error("counterclockwise ignore wrong");
  a_nv_hold: assert property (s_q.aux == AUX_VOLAT |=> !drv_out.nv_write_en) // [R5]
    else $error("store enabled in volatile mode");
  a_bw_order: assert property (s_q.stiff != 4'h0 |-> bw_of(s_q.stiff) > bw_of(s_q.stiff - 4'h1)) // [R8]
    else $error("bandwidth not rising");

  sequence s_auto2_steady;
    s_q.mode == M_AUTO2 && s_q.prev == M_AUTO2;
  endsequence
  a_bw_auto2: assert property (s_auto2_steady |=> ##1 drv_out.bw_hz == bw_of($past(s_q.stiff, 2))) // [R7] [R14]
    else $error("gain does not follow stiffness");
  a_manual_gain: assert property (s_q.mode == M_MAN && s_q.prev == M_MAN && !(wr && a == IDX_GAIN)
                                  |=> s_q.bw == $past(s_q.bw)) // [R9]
    else $error("stiffness moved manual gain");
  a_leave_auto1: assert property (s_q.prev == M_AUTO1 && s_q.mode == M_AUTO2
                                  |=> s_q.inertia == $past(drv_in.meas_inertia)) // [R12]
    else $error("measured inertia not stored");
  a_restore: assert property (s_q.prev == M_AUTO2 && s_q.mode == M_MAN
                              |=> s_q.inertia == $past(s_q.snap_in) && s_q.bw == $past(s_q.snap_bw)) // [R15]
    else $error("manual values not restored");
  a_periodic: assert property (s_q.mode == M_AUTO1 && s_q.prev == M_AUTO1
                               && s_q.tmr == SAVE_CYCLES - 40'h1 |=> s_q.sts[ST_SAVE]
                               && s_q.tmr == 40'h0) // [R13]
    else $error("periodic save missed");
  a_overspeed: assert property (os_hit |=> drv_out.fault_code == FC_OVSPD && (!s_q.en[ST_OVSPD] || irq)) // [R16]
    else $error("overspeed fault not raised");
  a_pos_error: assert property (pe_hit && !os_hit && !s_q.sts[ST_OVSPD]
                                |=> drv_out.fault_code == FC_PERR) // [R17]
    else $error("position error fault not raised");
  a_fault_latch: assert property (s_q.sts[ST_PERR] && !(wr && a == IDX_IRQ_CLR)
                                  |=> s_q.sts[ST_PERR]) // [R18]
    else $error("fault dropped without clear");
  a_loop_field: assert property (s_q.loop_pi |=> drv_out.loop_pi) // [R11]
    else $error("loop structure not applied");
  a_fixed_inertia: assert property (s_auto2_steady and !(wr && a == IDX_INERTIA)
                                    |=> s_q.inertia == $past(s_q.inertia)) // [R10]
    else $error("inertia moved in fixed mode");
endmodule // sat_params

// [rtl/sat_pkg.sv]
/*
  sat_pkg: constants, register indices, field layouts and carrier
  types for the servo tuning and fault supervision block.
  assumes a 250 MHz pclk and an APB slave with 12-bit byte addresses.
*/
package sat_pkg;
  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_AUX     = 10'h21E;
  localparam logic [9:0] IDX_STIFF   = 10'h21F;
  localparam logic [9:0] IDX_RSVD_A  = 10'h221;
  localparam logic [9:0] IDX_OS_THR  = 10'h222;
  localparam logic [9:0] IDX_PE_THR  = 10'h223;
  localparam logic [9:0] IDX_TUNE    = 10'h240;
  localparam logic [9:0] IDX_INERTIA = 10'h241;
  localparam logic [9:0] IDX_GAIN    = 10'h242;
  localparam logic [9:0] IDX_FAULT   = 10'h243;
  localparam logic [9:0] IDX_IRQ_STS = 10'h244;
  localparam logic [9:0] IDX_IRQ_CLR = 10'h245;
  localparam logic [9:0] IDX_IRQ_EN  = 10'h246;
  // auxiliary function codes
  localparam logic [2:0] AUX_NORMAL  = 3'h0;
  localparam logic [2:0] AUX_FORCE   = 3'h1;
  localparam logic [2:0] AUX_NO_CW   = 3'h2;
  localparam logic [2:0] AUX_NO_CCW  = 3'h3;
  localparam logic [2:0] AUX_VOLAT   = 3'h5;
  // tuning register fields and modes
  localparam int         TUNE_MODE_LSB = 0;
  localparam int         TUNE_LOOP_BIT = 4;
  localparam logic [1:0] M_MAN   = 2'h0;
  localparam logic [1:0] M_AUTO1 = 2'h1;
  localparam logic [1:0] M_AUTO2 = 2'h2;
  // control modes seen on the drive input
  localparam logic [1:0] CM_POS   = 2'h0;
  localparam logic [1:0] CM_SPEED = 2'h1;
  // threshold ranges and reset values
  localparam logic [15:0] OS_MIN = 16'h0001;
  localparam logic [15:0] OS_MAX = 16'h1770;
  localparam logic [15:0] OS_RST = 16'h1388;
  localparam logic [15:0] PE_MIN = 16'h0001;
  localparam logic [15:0] PE_MAX = 16'h7530;
  localparam logic [15:0] PE_RST = 16'h0BB8;
  localparam logic [31:0] PE_UNIT = 32'h0000000A;
  localparam logic [3:0]  STIFF_RST = 4'h6;
  localparam logic [15:0] INERTIA_RST = 16'h000A;
  localparam logic [7:0]  GAIN_RST = 8'h2D;
  // fault codes
  localparam logic [7:0] FC_NONE  = 8'h00;
  localparam logic [7:0] FC_OVSPD = 8'h07;
  localparam logic [7:0] FC_PERR  = 8'h09;
  // status bits
  localparam int ST_OVSPD = 0;
  localparam int ST_PERR  = 1;
  localparam int ST_SAVE  = 2;
  // speed-loop bandwidth per stiffness level, in Hz
  localparam logic [7:0] BW_HZ [16] = '{8'h0A, 8'h0F, 8'h14, 8'h19, 8'h1E, 8'h23, 8'h2D, 8'h37,
                                        8'h41, 8'h50, 8'h64, 8'h78, 8'h91, 8'hAA, 8'hCD, 8'hFA};
  // periodic inertia save time
  localparam longint unsigned SAVE_MIN = 30;
  localparam longint unsigned CLK_NS   = 4;
  localparam longint unsigned SAVE_CYC = SAVE_MIN * 60 * 1000000000 / CLK_NS;

  typedef struct packed {
    logic        servo_on;
    logic        cw_inh;
    logic        ccw_inh;
    logic [1:0]  ctrl_mode;
    logic [15:0] speed_rpm;
    logic [31:0] pos_err;
    logic [15:0] meas_inertia;
  } sat_in_t;

  typedef struct packed {
    logic        servo_on;
    logic        cw_inh;
    logic        ccw_inh;
    logic        nv_write_en;
    logic        loop_pi;
    logic [7:0]  bw_hz;
    logic [15:0] inertia;
    logic [7:0]  fault_code;
  } sat_out_t;
endpackage

// [tb/sat_motor.sv]
/*
  sat_motor: motor and encoder on the far side of the drive signals.
  assumes bench commands in the pclk domain; one cycle of sensor delay.
*/
`timescale 1ns/10ps
module sat_motor
  import sat_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire sat_pkg::sat_out_t drv_out,
  input  wire sat_pkg::sat_in_t  cmd,
  output sat_pkg::sat_in_t       drv_in
);
  // sensors report one cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_in <= '0;
    end else begin
      drv_in <= cmd;
      // an unpowered shaft coasts to rest, so no speed shows
      if (!drv_out.servo_on) begin
        drv_in.speed_rpm <= 16'h0;
      end
    end
  end
endmodule // sat_motor

// [tb/sat_params_tb_top.sv]
/*
  sat_params_tb_top: self-checking bench for the tuning and fault block.
  assumes sat_pkg, sat_params and sat_motor are compiled before it.
*/
`timescale 1ns/10ps
module sat_params_tb_top;
  import sat_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, e;
  logic [7:0]  pbw;
  sat_in_t     cmd, drv_in; // cmd: what the bench asks of the motor
  sat_out_t    drv_out;
  int          error_cnt, check_count, lim;
  int          bw[16] = '{10, 15, 20, 25, 30, 35, 45, 55, 65, 80, 100, 120, 145, 170, 205, 250};
  int          aux_q[$] = '{0, 1, 2, 3, 5};

  // short save interval keeps the periodic store reachable
  sat_params #(.SAVE_CYCLES(40'h14)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .drv_in(drv_in), .drv_out(drv_out), .irq(irq));
  sat_motor u_motor (.pclk(pclk), .presetn(presetn), .drv_out(drv_out), .cmd(cmd), .drv_in(drv_in));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // the sequence needs a few hundred cycles; far beyond that is a hang
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    complete_run();
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic w(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic fail_if(input logic bad, input string m);
    check_count++;
    if (bad !== 1'b0) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] x);
    fail_if(g !== x, "register value");
  endtask
  task automatic chk_drv(input logic [31:0] g, input logic [31:0] x);
    fail_if(g !== x, "drive output");
  endtask
  // one APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [9:0] i, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    fail_if(pready !== 1'b1, "no pready");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [9:0] i, input logic [31:0] x);
    apb(1'b0, i, 32'h0);
    chk_reg(rd, x);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    cmd = '0;
    seed = 32'h9592AF22;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, reserved slot and an unmapped index
    rdc(IDX_AUX, 32'h0);
    rdc(IDX_STIFF, 32'h6);
    rdc(IDX_OS_THR, 32'h1388);
    rdc(IDX_PE_THR, 32'h0BB8);
    rdc(IDX_RSVD_A, 32'h0);
    rdc(10'h300, 32'h0);
    chk_reg({31'h0, err}, 32'h1);
    $display("test reset done");
    // each selector code except reserved 4 against random input levels
    foreach (aux_q[k]) begin
      apb(1'b1, IDX_AUX, 32'(aux_q[k]));
      repeat (3) begin
        seed = lfsr(seed);
        cmd.servo_on <= seed[0];
        cmd.cw_inh <= seed[1];
        cmd.ccw_inh <= seed[2];
        w(4);
        e = {28'h0, seed[0] | (aux_q[k] == 1), seed[1] & !(aux_q[k] inside {1, 2}),
             seed[2] & !(aux_q[k] inside {1, 3}), aux_q[k] != 5};
        chk_drv({28'h0, drv_out.servo_on, drv_out.cw_inh, drv_out.ccw_inh, drv_out.nv_write_en}, e);
      end
    end
    // a second power-up brings the selector back to normal
    presetn <= 1'b0;
    w(2);
    presetn <= 1'b1;
    rdc(IDX_AUX, 32'h0);
    $display("test aux done");
    // manual values, then auto mode 1 with its periodic store
    cmd.servo_on <= 1'b1;
    cmd.meas_inertia <= 16'h0055;
    apb(1'b1, IDX_INERTIA, 32'h20);
    apb(1'b1, IDX_GAIN, 32'h40);
    apb(1'b1, IDX_STIFF, 32'h3);
    apb(1'b1, IDX_TUNE, 32'h10);
    w(4);
    chk_drv({7'h0, drv_out.loop_pi, drv_out.inertia, drv_out.bw_hz}, 32'h01002040);
    apb(1'b1, IDX_IRQ_EN, 32'h4);
    apb(1'b1, IDX_TUNE, 32'h1);
    apb(1'b1, IDX_IRQ_CLR, 32'h7);
    w(30);
    chk_drv({30'h0, drv_out.loop_pi, irq}, 32'h1);
    rdc(IDX_INERTIA, 32'h55);
    cmd.meas_inertia <= 16'h0066;
    w(2);
    apb(1'b1, IDX_TUNE, 32'h2);
    w(2);
    cmd.meas_inertia <= 16'h0077; // later measurements must not leak in
    pbw = 8'h0;
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, IDX_STIFF, 32'(i));
      w(3);
      chk_drv({8'h0, drv_out.inertia, drv_out.bw_hz}, {8'h0, 16'h0066, 8'(bw[i])});
      chk_drv({31'h0, drv_out.bw_hz > pbw}, 32'h1);
      pbw = drv_out.bw_hz;
    end
    apb(1'b1, IDX_TUNE, 32'h0);
    w(3);
    chk_drv({8'h0, drv_out.inertia, drv_out.bw_hz}, 32'h00002040);
    $display("test tuning done");
    // thresholds clamp at the top of their range
    apb(1'b1, IDX_OS_THR, 32'h1B58);
    rdc(IDX_OS_THR, 32'h1770);
    apb(1'b1, IDX_PE_THR, 32'h7531);
    rdc(IDX_PE_THR, 32'h7530);
    // k 0: overspeed in speed mode, k 1: excess error in position mode
    for (int k = 0; k < 2; k++) begin
      cmd.ctrl_mode <= k ? CM_POS : CM_SPEED;
      apb(1'b1, k ? IDX_PE_THR : IDX_OS_THR, 32'h5);
      apb(1'b1, IDX_IRQ_EN, 32'h0);
      lim = k ? 50 : 5;
      // at the threshold nothing, one above it the fault
      for (int v = 0; v < 2; v++) begin
        cmd.speed_rpm <= k ? 16'h0 : 16'(lim + v);
        cmd.pos_err <= k ? 32'(lim + v) : 32'h0;
        w(4);
        chk_drv({23'h0, irq, drv_out.fault_code}, v ? (k ? 32'h9 : 32'h7) : 32'h0);
      end
      cmd.speed_rpm <= 16'h0;
      cmd.pos_err <= 32'h0;
      rdc(IDX_FAULT, k ? 32'h9 : 32'h7);
      apb(1'b1, IDX_IRQ_EN, 32'h3);
      w(2);
      chk_drv({31'h0, irq}, 32'h1);
      apb(1'b1, IDX_IRQ_CLR, 32'h3);
      w(2);
      chk_drv({23'h0, irq, drv_out.fault_code}, 32'h0);
    end
    $display("test faults done");
    complete_run();
  end
endmodule // sat_params_tb_top
